// ---- logic/csuc_pkg.sv ----
// shared constants, carriers and helpers of the security gate
// assumes a single system clock and an apb slave port
package csuc_pkg;

    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;
    localparam int          KEY_WORDS      = 4;
    localparam int          SYNC_STAGES    = 2;

    // -------------------------------------------------------------
    // register map
    // -------------------------------------------------------------
    localparam logic [11:0] OFS_STATUS     = 12'h000;
    localparam logic [11:0] OFS_KEY01      = 12'h004;
    localparam logic [11:0] OFS_KEY23      = 12'h008;
    localparam logic [11:0] OFS_CTRL       = 12'h00C;
    localparam int          CTRL_KEY_CHECK = 0;
    localparam int          ST_SECURED     = 0;
    localparam int          ST_NORMAL      = 1;
    localparam int          ST_KEY_UNSEC   = 2;
    localparam int          ST_ERASE_UNSEC = 3;
    localparam int          ST_DBG_ACTIVE  = 4;
    localparam int          ST_COPY_LSB    = 8;

    // -------------------------------------------------------------
    // option byte layout
    // -------------------------------------------------------------
    localparam int          SEC_LSB        = 0;
    localparam int          KEYEN_LSB      = 6;
    localparam logic [1:0]  SEC_UNSEC      = 2'b10;
    localparam logic [1:0]  KEYEN_ON       = 2'b10;
    localparam logic [7:0]  COPY_RESET     = 8'hFF;
    localparam logic [15:0] KEY_ZERO       = 16'h0000;
    localparam logic [15:0] KEY_ONES       = 16'hFFFF;
    localparam logic [23:0] OPT_SECT_LO    = 24'h7F_FE00;
    localparam logic [23:0] OPT_SECT_HI    = 24'h7F_FFFF;

    typedef enum logic [1:0] {
        DBG_MEM        = 2'd0,
        DBG_CSR        = 2'd1,
        DBG_MASS_ERASE = 2'd2,
        DBG_OTHER      = 2'd3
    } csuc_dbg_kind_t;

    typedef enum logic [2:0] {
        NVM_READ       = 3'd0,
        NVM_PROG       = 3'd1,
        NVM_ERASE_SECT = 3'd2,
        NVM_ERASE_ALL  = 3'd3,
        NVM_OPT_ERASE  = 3'd4,
        NVM_OPT_PROG   = 3'd5
    } csuc_nvm_kind_t;

    typedef struct packed {
        logic           valid;
        csuc_dbg_kind_t kind;
    } csuc_dbg_req_t;

    typedef struct packed {
        logic accept;
        logic reject;
    } csuc_dbg_resp_t;

    typedef struct packed {
        logic           valid;
        csuc_nvm_kind_t kind;
    } csuc_nvm_req_t;

    typedef struct packed {
        logic        grant;
        logic        deny;
        logic [23:0] erase_lo;
        logic [23:0] erase_hi;
        logic        sec_prog_req;
        logic [7:0]  sec_prog_val;
    } csuc_nvm_resp_t;

    typedef struct packed {
        logic [7:0]                 opt_byte;
        logic [KEY_WORDS-1:0][15:0] key_store;
        logic                       opt_sector_protected;
        logic                       erase_all_done;
    } csuc_flash_in_t;

    typedef struct packed {
        logic secured;
        logic normal_mode;
        logic active_debug_state;
        logic debug_port_enable;
        logic mem_access_block;
        logic nvm_read_block;
        logic nvm_cmd_restrict;
    } csuc_sec_out_t;

    function automatic logic key_word_ok(input logic [15:0] w);
        return (w != KEY_ZERO) && (w != KEY_ONES);
    endfunction : key_word_ok

endpackage : csuc_pkg

// ---- logic/csuc_key_cmp.sv ----
// backdoor key comparator, purely combinational
// assumes both key sets are stable in the cycle they are compared
module csuc_key_cmp
    import csuc_pkg::*;
(
    input  wire logic [KEY_WORDS-1:0][15:0] stored,
    input  wire logic [KEY_WORDS-1:0][15:0] written,
    output logic                            stored_ok,
    output logic                            match
);

    // -------------------------------------------------------------
    // per-word validity and equality
    // -------------------------------------------------------------
    always_comb
    begin
        stored_ok = 1'b1;
        match     = 1'b1;
        for (int i = 0; i < KEY_WORDS; i++)
        begin
            stored_ok = stored_ok & key_word_ok(stored[i]);
            match     = match & key_word_ok(written[i])
                        & (written[i] == stored[i]);
        end
    end

endmodule : csuc_key_cmp

// ---- logic/csuc_gate.sv ----
// chip security gate: mode capture, security copy, debug and nvm gating
// assumes flash inputs are stable at reset release, apb master on pclk
//
// Implementation choices: the APB slave port and the placing of the registers.
module csuc_gate
    import csuc_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic             chip_mode_select,
    input  wire csuc_flash_in_t   flash_in,
    input  wire csuc_dbg_req_t    dbg_req,
    output csuc_dbg_resp_t        dbg_resp,
    input  wire csuc_nvm_req_t    nvm_req,
    output csuc_nvm_resp_t        nvm_resp,
    output csuc_sec_out_t         sec_out
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_INIT0 = 4'b0001,
        ST_INIT1 = 4'b0010,
        ST_INIT2 = 4'b0100,
        ST_RUN   = 4'b1000
    } csuc_phase_t;

    typedef struct packed {
        logic                       mode_s1;
        logic                       mode_s2;
        csuc_phase_t                phase;
        logic [7:0]                 copy;
        logic                       key_unsec;
        logic                       erase_unsec;
        logic [KEY_WORDS-1:0][15:0] key;
        csuc_sec_out_t              so;
        csuc_dbg_resp_t             dr;
        csuc_nvm_resp_t             nr;
        logic                       pready;
        logic                       pslverr;
        logic [DATA_W-1:0]          prdata;
    } csuc_state_t;

    localparam csuc_state_t RESET_STATE = '{
        mode_s1:     1'b0,
        mode_s2:     1'b0,
        phase:       ST_INIT0,
        copy:        COPY_RESET,
        key_unsec:   1'b0,
        erase_unsec: 1'b0,
        key:         '0,
        so:          '{secured: 1'b1, default: 1'b0},
        dr:          '0,
        nr:          '0,
        pready:      1'b0,
        pslverr:     1'b0,
        prdata:      '0
    };

    csuc_state_t state_ff;
    csuc_state_t nxt_state;
    logic        key_stored_ok;
    logic        key_match;
    logic        apb_setup;
    logic        apb_commit;
    logic        mapped;
    logic        dbg_ok;
    logic        nvm_ok;
    logic        key_try;

    // -------------------------------------------------------------
    // key comparator
    // -------------------------------------------------------------
    csuc_key_cmp u_key_cmp (
        .stored    (flash_in.key_store),
        .written   (state_ff.key),
        .stored_ok (key_stored_ok),
        .match     (key_match)
    );

    assign apb_setup  = psel & penable & ~state_ff.pready;
    assign apb_commit = psel & penable & state_ff.pready;
    assign mapped     = (paddr == OFS_STATUS) | (paddr == OFS_KEY01)
                      | (paddr == OFS_KEY23) | (paddr == OFS_CTRL);
    assign key_try    = apb_commit & pwrite & (paddr == OFS_CTRL)
                      & pwdata[CTRL_KEY_CHECK];

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb
    begin
        nxt_state                 = state_ff;
        dbg_ok                    = 1'b0;
        nvm_ok                    = 1'b0;
        nxt_state.mode_s1         = chip_mode_select;
        nxt_state.mode_s2         = state_ff.mode_s1;
        nxt_state.dr              = '0;
        nxt_state.nr.grant        = 1'b0;
        nxt_state.nr.deny         = 1'b0;
        nxt_state.nr.sec_prog_req = 1'b0;

        unique case (state_ff.phase)
            ST_INIT0: nxt_state.phase = ST_INIT1;
            ST_INIT1: nxt_state.phase = ST_INIT2;
            ST_INIT2:
            begin
                nxt_state.phase                 = ST_RUN;
                nxt_state.so.normal_mode        = state_ff.mode_s2;
                nxt_state.so.active_debug_state = ~state_ff.mode_s2;
                nxt_state.copy                  = flash_in.opt_byte;
            end
            ST_RUN:
            begin
                if (dbg_req.valid)
                begin
                    dbg_ok = ~state_ff.so.secured
                           | (~state_ff.so.normal_mode
                              & ((dbg_req.kind == DBG_CSR)
                                 | (dbg_req.kind == DBG_MASS_ERASE)));
                    nxt_state.dr.accept = dbg_ok;
                    nxt_state.dr.reject = ~dbg_ok;
                end
                if (nvm_req.valid)
                begin
                    unique case (nvm_req.kind)
                        NVM_READ:      nvm_ok = ~state_ff.so.secured;
                        NVM_OPT_ERASE,
                        NVM_OPT_PROG:  nvm_ok = ~flash_in.opt_sector_protected;
                        default:       nvm_ok = 1'b1;
                    endcase
                    nxt_state.nr.grant = nvm_ok;
                    nxt_state.nr.deny  = ~nvm_ok;
                    if (nvm_ok && (nvm_req.kind == NVM_OPT_ERASE))
                    begin
                        nxt_state.nr.erase_lo = OPT_SECT_LO;
                        nxt_state.nr.erase_hi = OPT_SECT_HI;
                    end
                end
                if (flash_in.erase_all_done)
                begin
                    nxt_state.erase_unsec     = 1'b1;
                    nxt_state.nr.sec_prog_req = 1'b1;
                    nxt_state.nr.sec_prog_val = {state_ff.copy[7:2], SEC_UNSEC};
                end
                if (key_try && state_ff.so.normal_mode
                    && (state_ff.copy[KEYEN_LSB +: 2] == KEYEN_ON)
                    && key_stored_ok && key_match)
                begin
                    nxt_state.key_unsec = 1'b1;
                end
            end
            default: nxt_state.phase = ST_INIT0;
        endcase

        // derived security outputs
        if (nxt_state.phase == ST_RUN)
        begin
            nxt_state.so.secured = (nxt_state.copy[SEC_LSB +: 2] != SEC_UNSEC)
                                 & ~nxt_state.key_unsec & ~nxt_state.erase_unsec;
        end
        nxt_state.so.debug_port_enable = ~(nxt_state.so.secured
                                          & nxt_state.so.normal_mode);
        nxt_state.so.mem_access_block  = nxt_state.so.secured;
        nxt_state.so.nvm_read_block    = nxt_state.so.secured;
        nxt_state.so.nvm_cmd_restrict  = nxt_state.so.secured;

        // apb slave, one wait state
        nxt_state.pready = apb_setup;
        if (apb_setup)
        begin
            nxt_state.pslverr = ~mapped;
            nxt_state.prdata  = '0;
            if (!pwrite && (paddr == OFS_STATUS))
            begin
                nxt_state.prdata[ST_SECURED]          = state_ff.so.secured;
                nxt_state.prdata[ST_NORMAL]           = state_ff.so.normal_mode;
                nxt_state.prdata[ST_KEY_UNSEC]        = state_ff.key_unsec;
                nxt_state.prdata[ST_ERASE_UNSEC]      = state_ff.erase_unsec;
                nxt_state.prdata[ST_DBG_ACTIVE]       = state_ff.so.active_debug_state;
                nxt_state.prdata[ST_COPY_LSB +: 8]    = state_ff.copy;
            end
        end
        else
        begin
            nxt_state.pslverr = 1'b0;
        end
        if (apb_commit && pwrite)
        begin
            if (paddr == OFS_KEY01)
            begin
                nxt_state.key[0] = pwdata[15:0];
                nxt_state.key[1] = pwdata[31:16];
            end
            if (paddr == OFS_KEY23)
            begin
                nxt_state.key[2] = pwdata[15:0];
                nxt_state.key[3] = pwdata[31:16];
            end
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= RESET_STATE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign prdata   = state_ff.prdata;
    assign pready   = state_ff.pready;
    assign pslverr  = state_ff.pslverr;
    assign dbg_resp = state_ff.dr;
    assign nvm_resp = state_ff.nr;
    assign sec_out  = state_ff.so;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_key_written;
        key_try && state_ff.so.normal_mode && (state_ff.phase == ST_RUN);
    endsequence

    sequence s_key_good;
        (state_ff.copy[KEYEN_LSB +: 2] == KEYEN_ON) && key_stored_ok && key_match;
    endsequence

    a_debug_on_release: assert property (
        (state_ff.phase == ST_INIT2) |=> (sec_out.active_debug_state == $past(state_ff.mode_s2) ^ 1'b1))
        else $error("debug state wrong after reset release");

    a_ss_cmd_filter: assert property (
        (state_ff.phase == ST_RUN) && dbg_req.valid && state_ff.so.secured
        && !state_ff.so.normal_mode && (dbg_req.kind inside {DBG_MEM, DBG_OTHER})
        |=> dbg_resp.reject && !dbg_resp.accept)
        else $error("secured special mode accepted a forbidden command");

    a_ns_dbg_off: assert property (
        sec_out.secured && sec_out.normal_mode
        |-> !sec_out.debug_port_enable && !dbg_resp.accept)
        else $error("debug port live while secured in normal mode");

    a_no_nvm_read: assert property (
        (state_ff.phase == ST_RUN) && nvm_req.valid && (nvm_req.kind == NVM_READ)
        && state_ff.so.secured |=> nvm_resp.deny && sec_out.nvm_read_block)
        else $error("nvm read granted while secured");

    a_opt_protect: assert property (
        (state_ff.phase == ST_RUN) && nvm_req.valid
        && (nvm_req.kind inside {NVM_OPT_ERASE, NVM_OPT_PROG})
        |=> nvm_resp.grant == !$past(flash_in.opt_sector_protected))
        else $error("option byte change gating wrong");

    a_opt_range: assert property (
        $rose(nvm_resp.grant) && ($past(nvm_req.kind) == NVM_OPT_ERASE)
        |-> (nvm_resp.erase_lo == OPT_SECT_LO) && (nvm_resp.erase_hi == OPT_SECT_HI))
        else $error("option erase range wrong");

    a_key_unlock: assert property (
        s_key_written ##0 s_key_good |=> !sec_out.secured ##1 !sec_out.secured)
        else $error("valid backdoor key did not unsecure");

    a_key_invalid: assert property (
        (s_key_written and (!key_stored_ok && !state_ff.key_unsec)) |=> !state_ff.key_unsec)
        else $error("invalid key accepted");

    a_field_decode: assert property (
        (state_ff.phase == ST_RUN) && !state_ff.key_unsec && !state_ff.erase_unsec
        |-> sec_out.secured == (state_ff.copy[SEC_LSB +: 2] != SEC_UNSEC))
        else $error("security field decode wrong");

    a_erase_all: assert property (
        (state_ff.phase == ST_RUN) && flash_in.erase_all_done
        |=> !sec_out.secured && nvm_resp.sec_prog_req
            && (nvm_resp.sec_prog_val[SEC_LSB +: 2] == SEC_UNSEC) ##1 !nvm_resp.sec_prog_req)
        else $error("full erase did not unsecure");

    a_copy_frozen: assert property (
        (state_ff.phase == ST_RUN) |=> $stable(state_ff.copy))
        else $error("security copy changed outside reset");

    a_copy_load: assert property (
        (state_ff.phase == ST_INIT2) |=> (state_ff.copy == $past(flash_in.opt_byte)))
        else $error("option byte not copied during reset sequence");

    a_mode_latch: assert property (
        (state_ff.phase == ST_INIT2) |=> (sec_out.normal_mode == $past(state_ff.mode_s2)))
        else $error("chip mode not latched at reset release");

    a_ss_allowed: assert property (
        (state_ff.phase == ST_RUN) && dbg_req.valid && state_ff.so.secured
        && !state_ff.so.normal_mode && (dbg_req.kind inside {DBG_CSR, DBG_MASS_ERASE})
        |=> dbg_resp.accept && !dbg_resp.reject)
        else $error("secured special mode refused an allowed command");

    a_restrict_level: assert property (
        sec_out.secured && (state_ff.phase != ST_INIT0)
        |-> sec_out.nvm_cmd_restrict && sec_out.mem_access_block)
        else $error("restriction outputs low while secured");

    a_key_disabled: assert property (
        (s_key_written and ((state_ff.copy[KEYEN_LSB +: 2] != KEYEN_ON) && !state_ff.key_unsec))
        |=> !state_ff.key_unsec)
        else $error("key accepted with key access disabled");

    a_key_held: assert property (
        state_ff.key_unsec |=> state_ff.key_unsec && !sec_out.secured)
        else $error("key unsecure lost before reset");

    a_erase_sticky: assert property (
        state_ff.erase_unsec |=> state_ff.erase_unsec && !sec_out.secured)
        else $error("erase unsecure lost before reset");

endmodule : csuc_gate

// ---- test/csuc_dbg_host.sv ----
// behavioural debug host on the background debug link
// assumes one pclk domain shared with the security gate
module csuc_dbg_host
    import csuc_pkg::*;
(
    input  wire logic           pclk,
    output csuc_dbg_req_t       dbg_req,
    input  wire csuc_dbg_resp_t dbg_resp
);
    timeunit 1ns;
    timeprecision 1ns;

    initial dbg_req = '{valid: 1'b0, kind: DBG_OTHER};

    // -------------------------------------------------------------
    // one command, answer taken mid-cycle after the taking edge
    // -------------------------------------------------------------
    task automatic send(input csuc_dbg_kind_t k, output logic acc, output logic rej);
        @(posedge pclk);
        dbg_req <= '{valid: 1'b1, kind: k};
        @(posedge pclk);
        // released kind shows the inverse, never the last value
        dbg_req <= '{valid: 1'b0, kind: csuc_dbg_kind_t'(~k)};
        @(negedge pclk);
        acc = dbg_resp.accept;
        rej = dbg_resp.reject;
    endtask : send
endmodule : csuc_dbg_host

// ---- test/chip_security_unlock_control_tb.sv ----
// self-checking bench of the security gate
// assumes csuc_pkg, csuc_gate and csuc_dbg_host compiled before
module chip_security_unlock_control_tb
    import csuc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic              chip_mode_select;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    csuc_flash_in_t    fin;
    csuc_dbg_req_t     dbg_req;
    csuc_dbg_resp_t    dbg_resp;
    csuc_nvm_req_t     nvm_req;
    csuc_nvm_resp_t    nvm_resp;
    csuc_sec_out_t     sec_out;
    int                n_mismatch = 0;
    int                compares   = 0;
    logic [31:0]       seed       = 32'h0000_11f5;

    csuc_gate i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_mode_select(chip_mode_select),
        .flash_in(fin), .dbg_req(dbg_req), .dbg_resp(dbg_resp), .nvm_req(nvm_req),
        .nvm_resp(nvm_resp), .sec_out(sec_out));

    csuc_dbg_host i_host (.pclk(pclk), .dbg_req(dbg_req), .dbg_resp(dbg_resp));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic dbg_exp(logic sec, logic nrm, int k);
        if (!sec)
            return 1'b1;
        if (nrm)
            return 1'b0;
        return (k == 1) || (k == 2);
    endfunction : dbg_exp

    function automatic logic nvm_exp(logic sec, logic prot, int k);
        if (sec && k == 0)
            return 1'b0;
        return !(prot && (k == 4 || k == 5));
    endfunction : nvm_exp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic boot(input logic mode, input logic [7:0] opt);
        @(posedge pclk);
        presetn          <= 1'b0;
        chip_mode_select <= mode;
        fin.opt_byte     <= opt;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
    endtask : boot

    task automatic nvm(input int k);
        @(posedge pclk);
        nvm_req <= '{valid: 1'b1, kind: csuc_nvm_kind_t'(k)};
        @(posedge pclk);
        nvm_req <= '{valid: 1'b0, kind: csuc_nvm_kind_t'(~k)};
        @(negedge pclk);
    endtask : nvm

    task automatic key_try(input logic [3:0][15:0] k);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, OFS_KEY01, {k[1], k[0]}, rd, err);
        apb(1'b1, OFS_KEY23, {k[3], k[2]}, rd, err);
        apb(1'b1, OFS_CTRL, 32'h0000_0001, rd, err);
        repeat (2) @(negedge pclk);
    endtask : key_try

    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial
    begin
        logic [31:0]      r;
        logic [31:0]      rd;
        logic             err, acc, rej, sec, prot;
        logic [7:0]       opt;
        logic [3:0][15:0] ks;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        presetn = 1'b0;
        chip_mode_select = 1'b1;
        fin = '0;
        nvm_req = '0;
        for (int m = 0; m < 2; m++)
            for (int s = 0; s < 4; s++)
            begin
                r = xs();
                opt = {r[7:2], s[1:0]};
                prot = r[8];
                sec = (s != 2);
                @(posedge pclk) fin.opt_sector_protected <= prot;
                boot(m[0], opt);
                chk(sec_out.secured, sec, "secured");
                chk(sec_out.normal_mode, m[0], "mode");
                chk(sec_out.active_debug_state, !m[0], "debug active");
                chk(sec_out.debug_port_enable, !(sec && m[0]), "port");
                chk(sec_out.mem_access_block, sec, "mem block");
                chk({sec_out.nvm_read_block, sec_out.nvm_cmd_restrict}, {sec, sec}, "nvm block");
                apb(1'b0, OFS_STATUS, '0, rd, err);
                chk(rd, {16'h0000, opt, 3'b000, !m[0], 2'b00, m[0], sec}, "status");
                for (int k = 0; k < 4; k++)
                begin
                    i_host.send(csuc_dbg_kind_t'(k), acc, rej);
                    chk({acc, rej}, {dbg_exp(sec, m[0], k), !dbg_exp(sec, m[0], k)}, "dbg");
                end
                // option erase issued in normal mode too
                for (int k = 0; k < 6; k++)
                begin
                    nvm(k);
                    chk({nvm_resp.grant, nvm_resp.deny}, {nvm_exp(sec, prot, k), !nvm_exp(sec, prot, k)}, "nvm");
                end
                if (!prot)
                    chk({nvm_resp.erase_lo, 8'h00}, 32'h7FFE_0000, "erase lo");
                if (!prot)
                    chk({nvm_resp.erase_hi, 8'h00}, 32'h7FFF_FF00, "erase hi");
                $display("test sweep mode %0d field %0d done", m, s);
            end
        apb(1'b0, 12'h010, '0, rd, err);
        chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
        apb(1'b0, OFS_KEY01, '0, rd, err);
        chk(rd, 32'h0000_0000, "key readback");
        for (int c = 0; c < 4; c++)
        begin
            for (int w = 0; w < 4; w++)
            begin
                r = xs();
                ks[w] = {1'b0, r[14:1], 1'b1};
            end
            if (c == 3)
                ks[0] = 16'h0000;
            @(posedge pclk) fin.key_store <= ks;
            boot(c != 2, (c == 1) ? 8'h41 : 8'h81);
            if (c == 0)
            begin
                key_try({ks[3], ks[2] ^ 16'h0002, ks[1], ks[0]});
                chk(sec_out.secured, 1'b1, "wrong key");
            end
            key_try(ks);
            chk(sec_out.secured, c != 0, "key unlock");
            if (c == 0)
            begin
                apb(1'b0, OFS_STATUS, '0, rd, err);
                chk(rd[ST_KEY_UNSEC], 1'b1, "key status");
                boot(1'b1, 8'h81);
                chk(sec_out.secured, 1'b1, "key after reset");
            end
            $display("test key case %0d done", c);
        end
        boot(1'b1, 8'h01);
        @(posedge pclk);
        fin.opt_byte <= 8'h02;
        repeat (4) @(negedge pclk);
        chk(sec_out.secured, 1'b1, "reprogram early");
        boot(1'b1, 8'h02);
        chk(sec_out.secured, 1'b0, "reprogram reset");
        boot(1'b1, 8'hFD);
        @(posedge pclk);
        fin.erase_all_done <= 1'b1;
        @(posedge pclk);
        fin.erase_all_done <= 1'b0;
        @(negedge pclk);
        chk({sec_out.secured, nvm_resp.sec_prog_req, nvm_resp.sec_prog_val}, 10'h1FE, "erase all");
        $display("test unsecure paths done");
        print_verdict();
    end

    initial
    begin
        repeat (30000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule : chip_security_unlock_control_tb
